// [rtl/vsft_pkg.sv]
// Package for the vertical sync and field line timing block.
// Assumes an 8-bit register port with byte addresses in the user sub map.
package vsft_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] VSFT_ADDR_NTSC_VS_START  = 8'hE5;
    localparam logic [7:0] VSFT_ADDR_NTSC_VS_END    = 8'hE6;
    localparam logic [7:0] VSFT_ADDR_NTSC_FLD_TOG   = 8'hE7;
    localparam logic [7:0] VSFT_ADDR_PAL_VS_START   = 8'hE8;
    localparam logic [7:0] VSFT_ADDR_PAL_VS_END     = 8'hE9;
    localparam logic [7:0] VSFT_ADDR_PAL_FLD_TOG    = 8'hEA;
    localparam logic [7:0] VSFT_ADDR_SYNC_PIN_SEL   = 8'h6B;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int         VSFT_CNT_MSB     = 4;
    localparam int         VSFT_SIGN_BIT    = 5;
    localparam int         VSFT_EVEN_BIT    = 6;
    localparam int         VSFT_ODD_BIT     = 7;
    localparam logic [7:0] VSFT_RST_NTSC_VS_START = 8'h05;
    localparam logic [7:0] VSFT_RST_NTSC_VS_END   = 8'h04;
    localparam logic [7:0] VSFT_RST_NTSC_FLD_TOG  = 8'h03;
    localparam logic [7:0] VSFT_RST_PAL_VS_START  = 8'h05;
    localparam logic [7:0] VSFT_RST_PAL_VS_END    = 8'h14;
    localparam logic [7:0] VSFT_RST_PAL_FLD_TOG   = 8'h03;
    localparam logic [2:0] VSFT_RST_PIN_SEL       = 3'h2;
    localparam logic [10:0] VSFT_LINE_MAX         = 11'h7FF;

    // Pin source codes
    typedef enum logic [2:0] {
        VSFT_SRC_HSYNC = 3'h0,
        VSFT_SRC_VSYNC = 3'h1,
        VSFT_SRC_FIELD = 3'h2,
        VSFT_SRC_DE    = 3'h3,
        VSFT_SRC_SFL   = 3'h4
    } vsft_src_e;

    // One timing register split into fields
    typedef struct packed {
        logic       odd_delay;
        logic       even_delay;
        logic       sign;
        logic [4:0] count;
    } vsft_timing_s;

    // Register write port
    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vsft_wr_s;

endpackage : vsft_pkg

// [rtl/vsft_timing.sv]
// Vertical sync and field line timing with NTSC and PAL register sets.
// Assumes line start and field boundary strobes come from the line-locked
// timing, synchronous to ref_clk; registers reached by an 8-bit port.
//
// What this block does
// R1 - NTSC: raise vsync the programmed start count of lines after rollover
// R2 - NTSC: lower vsync the programmed end count of lines after rollover
// R3 - NTSC: toggle field the programmed toggle count of lines after rollover
// R4 - PAL: raise vsync the programmed start count of lines after rollover
// R5 - PAL: lower vsync the programmed end count of lines after rollover
// R6 - PAL: toggle field the programmed toggle count of lines after rollover
// R7 - Software writes zero to every sign bit when programming counts
// R8 - NTSC: start-delay bit for current field adds one line to rise
// R9 - NTSC: end-delay bit for current field adds one line to fall
// R10 - NTSC: toggle-delay bit for current field adds one line to toggle
// R11 - PAL: start-delay bit for current field adds one line to rise
// R12 - PAL: end-delay bit for current field adds one line to fall
// R13 - PAL: toggle-delay bit for current field adds one line to toggle
// R14 - Reset defaults NTSC 5,4,3 and PAL 5,20,3; sign and delays zero
// R15 - Three-bit select routes hsync, vsync, field, DE or lock to pin
// R16 - Line counter rolls over each field; standard picks register set
`timescale 1ns/1ps

module vsft_timing
    import vsft_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Register port
    input  wire vsft_wr_s    reg_wr,
    input  wire logic [7:0]  reg_rd_addr,
    output logic      [7:0]  reg_rd_data,
    // Video timing inputs
    input  wire logic        line_start,
    input  wire logic        field_start,
    input  wire logic        pal_mode,
    input  wire logic        hsync_in,
    input  wire logic        data_enable_in,
    input  wire logic        subcarrier_lock_indicator,
    // Sync outputs
    output logic             vsync_out,
    output logic             field_out,
    output logic             sync_pin_out,
    output logic      [10:0] field_line_counter
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // True when this cycle writes the given address
    function automatic logic vsft_wr_hit(
        input vsft_wr_s   wr,
        input logic [7:0] addr
    );
        vsft_wr_hit = wr.wr_en && (wr.addr == addr);
    endfunction : vsft_wr_hit

    // Field view of the active standard's register
    function automatic vsft_timing_s vsft_pick(
        input logic         pal,
        input vsft_timing_s ntsc_val,
        input vsft_timing_s pal_val
    );
        vsft_pick = pal ? pal_val : ntsc_val;
    endfunction : vsft_pick

    // Target line: count plus one when this field's delay bit is set
    function automatic logic [10:0] vsft_target(
        input vsft_timing_s t,
        input logic         odd
    );
        logic dly;
        dly         = odd ? t.odd_delay : t.even_delay;
        vsft_target = {6'h00, t.count} + {10'h000, dly};
    endfunction : vsft_target

    // Next line matches target; extra bit keeps a saturated count off zero
    function automatic logic vsft_line_hit(
        input logic [10:0] cnt,
        input logic [10:0] tgt
    );
        logic [11:0] next_line;
        next_line     = {1'b0, cnt} + 12'h001;
        vsft_line_hit = (next_line == {1'b0, tgt});
    endfunction : vsft_line_hit

    // ----------------------------------------
    // Write strobes
    // ----------------------------------------
    // One strobe per mapped register
    logic wr_ntsc_vs_start;
    logic wr_ntsc_vs_end;
    logic wr_ntsc_fld_tog;
    logic wr_pal_vs_start;
    logic wr_pal_vs_end;
    logic wr_pal_fld_tog;
    logic wr_pin_sel;

    assign wr_ntsc_vs_start = vsft_wr_hit(reg_wr, VSFT_ADDR_NTSC_VS_START);
    assign wr_ntsc_vs_end   = vsft_wr_hit(reg_wr, VSFT_ADDR_NTSC_VS_END);
    assign wr_ntsc_fld_tog  = vsft_wr_hit(reg_wr, VSFT_ADDR_NTSC_FLD_TOG);
    assign wr_pal_vs_start  = vsft_wr_hit(reg_wr, VSFT_ADDR_PAL_VS_START);
    assign wr_pal_vs_end    = vsft_wr_hit(reg_wr, VSFT_ADDR_PAL_VS_END);
    assign wr_pal_fld_tog   = vsft_wr_hit(reg_wr, VSFT_ADDR_PAL_FLD_TOG);
    assign wr_pin_sel       = vsft_wr_hit(reg_wr, VSFT_ADDR_SYNC_PIN_SEL);

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] ntsc_vs_start_r;
    logic [7:0] ntsc_vs_end_r;
    logic [7:0] ntsc_fld_tog_r;
    logic [7:0] pal_vs_start_r;
    logic [7:0] pal_vs_end_r;
    logic [7:0] pal_fld_tog_r;
    logic [2:0] sync_pin_source_select_r;

    // Sign bits kept as written, never acted on
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ntsc_vs_start_r <= VSFT_RST_NTSC_VS_START; // R14
        end else if (wr_ntsc_vs_start) begin
            ntsc_vs_start_r <= reg_wr.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ntsc_vs_end_r <= VSFT_RST_NTSC_VS_END; // R14
        end else if (wr_ntsc_vs_end) begin
            ntsc_vs_end_r <= reg_wr.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ntsc_fld_tog_r <= VSFT_RST_NTSC_FLD_TOG; // R14
        end else if (wr_ntsc_fld_tog) begin
            ntsc_fld_tog_r <= reg_wr.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pal_vs_start_r <= VSFT_RST_PAL_VS_START; // R14
        end else if (wr_pal_vs_start) begin
            pal_vs_start_r <= reg_wr.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pal_vs_end_r <= VSFT_RST_PAL_VS_END; // R14
        end else if (wr_pal_vs_end) begin
            pal_vs_end_r <= reg_wr.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pal_fld_tog_r <= VSFT_RST_PAL_FLD_TOG; // R14
        end else if (wr_pal_fld_tog) begin
            pal_fld_tog_r <= reg_wr.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_pin_source_select_r <= VSFT_RST_PIN_SEL;
        end else if (wr_pin_sel) begin
            sync_pin_source_select_r <= reg_wr.wdata[2:0]; // R15
        end
    end

    // ----------------------------------------
    // Register read-back
    // ----------------------------------------
    logic [7:0] rd_data_nxt;
    logic [7:0] rd_data_r;

    // Unmapped addresses and reserved select bits read zero
    always_comb begin
        case (reg_rd_addr)
            VSFT_ADDR_NTSC_VS_START: rd_data_nxt = ntsc_vs_start_r;
            VSFT_ADDR_NTSC_VS_END:   rd_data_nxt = ntsc_vs_end_r;
            VSFT_ADDR_NTSC_FLD_TOG:  rd_data_nxt = ntsc_fld_tog_r;
            VSFT_ADDR_PAL_VS_START:  rd_data_nxt = pal_vs_start_r;
            VSFT_ADDR_PAL_VS_END:    rd_data_nxt = pal_vs_end_r;
            VSFT_ADDR_PAL_FLD_TOG:   rd_data_nxt = pal_fld_tog_r;
            VSFT_ADDR_SYNC_PIN_SEL:  rd_data_nxt = {5'h00, sync_pin_source_select_r};
            default:                 rd_data_nxt = 8'h00;
        endcase
    end

    // Read data one clock after the address
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign reg_rd_data = rd_data_r;

    // ----------------------------------------
    // Field views and standard selection
    // ----------------------------------------
    vsft_timing_s ntsc_rise_v;
    vsft_timing_s ntsc_fall_v;
    vsft_timing_s ntsc_tog_v;
    vsft_timing_s pal_rise_v;
    vsft_timing_s pal_fall_v;
    vsft_timing_s pal_tog_v;
    vsft_timing_s vs_start_sel;
    vsft_timing_s vs_end_sel;
    vsft_timing_s fld_tog_sel;

    assign ntsc_rise_v = vsft_timing_s'(ntsc_vs_start_r);
    assign ntsc_fall_v = vsft_timing_s'(ntsc_vs_end_r);
    assign ntsc_tog_v  = vsft_timing_s'(ntsc_fld_tog_r);
    assign pal_rise_v  = vsft_timing_s'(pal_vs_start_r);
    assign pal_fall_v  = vsft_timing_s'(pal_vs_end_r);
    assign pal_tog_v   = vsft_timing_s'(pal_fld_tog_r);

    // Standard picks the register set
    assign vs_start_sel = vsft_pick(pal_mode, ntsc_rise_v, pal_rise_v); // R1 R4 R16
    assign vs_end_sel   = vsft_pick(pal_mode, ntsc_fall_v, pal_fall_v); // R2 R5 R16
    assign fld_tog_sel  = vsft_pick(pal_mode, ntsc_tog_v, pal_tog_v);   // R3 R6 R16

    // ----------------------------------------
    // Line counter
    // ----------------------------------------
    logic [10:0] line_cnt_r;
    logic        line_cnt_sat;
    logic        odd_field_r;

    assign line_cnt_sat = (line_cnt_r == VSFT_LINE_MAX);

    // Field boundary zeroes the count; saturate on missing boundary
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_cnt_r <= 11'h000;
        end else if (field_start) begin
            line_cnt_r <= 11'h000; // R16
        end else if (line_start && !line_cnt_sat) begin
            line_cnt_r <= line_cnt_r + 11'h001;
        end
    end

    // Field parity from the field output, held at field boundary
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            odd_field_r <= 1'b0;
        end else if (field_start) begin
            odd_field_r <= field_r;
        end
    end

    assign field_line_counter = line_cnt_r;

    // ----------------------------------------
    // Line event decode
    // ----------------------------------------
    logic [10:0] rise_line;
    logic [10:0] fall_line;
    logic [10:0] tog_line;

    logic        line_edge;
    logic        rise_hit;
    logic        fall_hit;
    logic        tog_hit;

    assign rise_line = vsft_target(vs_start_sel, odd_field_r); // R8 R11
    assign fall_line = vsft_target(vs_end_sel, odd_field_r);   // R9 R12
    assign tog_line  = vsft_target(fld_tog_sel, odd_field_r);  // R10 R13
    // Events act on the first clock of a line; the boundary line has none
    assign line_edge = line_start && !field_start;
    assign rise_hit  = line_edge && vsft_line_hit(line_cnt_r, rise_line); // R1 R4
    assign fall_hit  = line_edge && vsft_line_hit(line_cnt_r, fall_line); // R2 R5
    assign tog_hit   = line_edge && vsft_line_hit(line_cnt_r, tog_line);  // R3 R6

    // ----------------------------------------
    // Sync and field generation
    // ----------------------------------------
    logic vsync_r;
    logic field_r;

    // Rise wins if both match the same line
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vsync_r <= 1'b0;
        end else if (rise_hit) begin
            vsync_r <= 1'b1; // R1 R4
        end else if (fall_hit) begin
            vsync_r <= 1'b0; // R2 R5
        end
    end

    // Toggle on the programmed line
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            field_r <= 1'b0;
        end else if (tog_hit) begin
            field_r <= ~field_r; // R3 R6
        end
    end

    assign vsync_out = vsync_r;
    assign field_out = field_r;

    // ----------------------------------------
    // Output pin source select
    // ----------------------------------------
    vsft_src_e pin_src;
    logic      pin_nxt;
    logic      pin_r;

    assign pin_src = vsft_src_e'(sync_pin_source_select_r);

    // Codes above four drive the pin low
    always_comb begin
        case (pin_src) // R15
            VSFT_SRC_HSYNC: pin_nxt = hsync_in;
            VSFT_SRC_VSYNC: pin_nxt = vsync_r;
            VSFT_SRC_FIELD: pin_nxt = field_r;
            VSFT_SRC_DE:    pin_nxt = data_enable_in;
            VSFT_SRC_SFL:   pin_nxt = subcarrier_lock_indicator;
            default:        pin_nxt = 1'b0;
        endcase
    end

    // One clock behind the chosen source
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    assign sync_pin_out = pin_r;

endmodule : vsft_timing

// [test/vsft_timing_sva.sv]
// Port checker for the line timing block.
// Assumes vsft_pkg compiled first; bound onto vsft_timing below.
`timescale 1ns/1ps
module vsft_timing_sva
    import vsft_pkg::*;
(
    input wire logic        ref_clk, sys_rst,
    input wire vsft_wr_s    reg_wr,
    input wire logic [7:0]  reg_rd_addr, reg_rd_data,
    input wire logic        line_start, field_start, pal_mode, hsync_in, data_enable_in,
    input wire logic        subcarrier_lock_indicator, vsync_out, field_out, sync_pin_out,
    input wire logic [10:0] field_line_counter
);
    logic [2:0] sel_r;
    logic [4:0] sh_w;
    assign sh_w = {subcarrier_lock_indicator, data_enable_in, field_out, vsync_out,
                   hsync_in} >> sel_r;
    always_ff @(posedge ref_clk or posedge sys_rst)
        if (sys_rst) sel_r <= VSFT_RST_PIN_SEL;
        else if (reg_wr.wr_en && reg_wr.addr == VSFT_ADDR_SYNC_PIN_SEL) sel_r <= reg_wr.wdata[2:0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    AST_CNT_CLR: assert property (field_start |=> field_line_counter == 11'h000)
        else $error("counter not cleared");
    AST_CNT_INC: assert property (line_start && !field_start && field_line_counter < 11'h7FF
        |=> field_line_counter == $past(field_line_counter) + 11'h001) else $error("bad step");
    AST_VS_RISE: assert property ($rose(vsync_out) |->
        $past(line_start && !field_start) && field_line_counter != 11'h000) else $error("bad rise");
    AST_VS_FALL: assert property ($fell(vsync_out) |-> $past(line_start && !field_start))
        else $error("bad fall");
    AST_FLD_TOG: assert property ($changed(field_out) |-> $past(line_start && !field_start))
        else $error("bad toggle");
    AST_REG_RW: assert property (reg_wr.wr_en && reg_wr.addr inside {[8'hE5:8'hEA]} ##1
        !reg_wr.wr_en && reg_rd_addr == $past(reg_wr.addr) |=> reg_rd_data == $past(reg_wr.wdata, 2))
        else $error("register lost write");
    AST_SEL_RD: assert property (reg_rd_addr == 8'h6B |=> reg_rd_data == {5'h00, $past(sel_r)})
        else $error("select readback");
    AST_PIN: assert property ($stable(sel_r) |-> sync_pin_out == $past(sh_w[0]))
        else $error("pin source");
    COV_PAL: cover property (pal_mode && $rose(vsync_out));
    COV_NTSC: cover property (!pal_mode && $rose(vsync_out));
    COV_TOG: cover property ($changed(field_out));
endmodule : vsft_timing_sva
bind vsft_timing vsft_timing_sva u_sva (.*);

// [test/vsft_sink.sv]
// Downstream video processor model: counts vsync pulses.
// Assumes sync levels launched on ref_clk.
`timescale 1ns/1ps
module vsft_sink (
    input wire logic ref_clk, sys_rst, vsync_in,
    output int       vs_count
);
    logic vs_d;
    always @(posedge ref_clk or posedge sys_rst) vs_d <= sys_rst ? 1'b0 : vsync_in;
    always @(posedge ref_clk or posedge sys_rst)
        vs_count <= sys_rst ? 0 : vs_count + int'(vsync_in && !vs_d);
endmodule : vsft_sink

// [test/vsft_timing_tb_top.sv]
// Testbench: line timing block against a line-level model.
// Assumes package, design, checker and sink model compiled first.
`timescale 1ns/1ps
module vsft_timing_tb_top
    import vsft_pkg::*;
;
    logic ref_clk = 1'b0, sys_rst = 1'b1, line_start = 1'b0, field_start = 1'b0;
    logic pal_mode = 1'b0, hsync_in = 1'b0, data_enable_in = 1'b0;
    logic subcarrier_lock_indicator = 1'b0, vsync_out, field_out, sync_pin_out;
    logic [7:0] reg_rd_addr = 8'h00, reg_rd_data;
    logic [10:0] field_line_counter;
    vsft_wr_s reg_wr = '0;
    int vs_count, err_count = 0, num_checks = 0, cnt = 0, odd = 0, vs = 0, fld = 0, nvs = 0, e;
    int rg [int];
    always #12.5 ref_clk = ~ref_clk;
    vsft_timing uut (.*);
    vsft_sink u_sink (.ref_clk, .sys_rst, .vsync_in(vsync_out), .vs_count);
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        err_count += int'(seen !== exp);
    endtask : chk
    task automatic end_sim;
        if (err_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic rd(input logic [7:0] a);
        @(negedge ref_clk) {reg_wr.wr_en, reg_rd_addr} = {1'b0, a};
        @(negedge ref_clk) chk(11'(reg_rd_data), 11'(rg.exists(a) ? rg[a] : 0));
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk) reg_wr = '{1'b1, a, d};
        rg[a] = d;
        rd(a);
    endtask : wr
    function automatic int tgt(int a);
        return (rg[a] & 8'h1F) + ((rg[a] >> (odd ? 7 : 6)) & 1);
    endfunction : tgt
    task automatic line(input logic fs);
        int b, p;
        @(negedge ref_clk) {line_start, field_start} = {1'b1, fs};
        @(negedge ref_clk) {line_start, field_start} = 2'h0;
        b = pal_mode ? 8'hE8 : 8'hE5;
        p = vs;
        odd = fs ? fld : odd;
        cnt = fs ? 0 : cnt + int'(cnt < 2047);
        if (!fs && cnt == tgt(b + 1)) vs = 0;
        if (!fs && cnt == tgt(b)) vs = 1;
        if (!fs && cnt == tgt(b + 2)) fld ^= 1;
        nvs += int'(vs == 1 && p == 0);
        chk(field_line_counter, 11'(cnt));
        chk(11'(vsync_out), 11'(vs));
        chk(11'(field_out), 11'(fld));
    endtask : line
    task automatic fields(input int n);
        for (int i = 0; i < n * 26; i++) line(i % 26 == 0);
    endtask : fields
    initial begin
        void'($urandom(87999));
        rg = '{8'hE5: 8'h05, 8'hE6: 8'h04, 8'hE7: 8'h03, 8'hE8: 8'h05, 8'hE9: 8'h14,
               8'hEA: 8'h03, 8'h6B: 8'h02};
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        foreach (rg[a]) rd(8'(a));
        rd(8'hEB);
        for (int m = 0; m < 2; m++) begin
            pal_mode = m[0];
            fields(2);
            repeat (3) begin
                for (int a = 0; a < 3; a++) wr(8'(8'hE5 + 3 * m + a), 8'($urandom) & 8'hDF);
                fields(2);
            end
        end
        for (int s = 0; s < 8; s++) begin
            wr(8'h6B, 8'(s));
            @(negedge ref_clk) {hsync_in, data_enable_in, subcarrier_lock_indicator} = 3'($urandom);
            e = ({subcarrier_lock_indicator, data_enable_in, fld[0], vs[0], hsync_in} >> s) & 1;
            @(negedge ref_clk) chk(11'(sync_pin_out), 11'(e));
        end
        chk(11'(vs_count), 11'(nvs));
        end_sim();
    end
    initial begin
        #250000 err_count++;
        end_sim();
    end
endmodule : vsft_timing_tb_top
